// ---- rtl/imu_output_data_registers.sv ----
// z accel, temperature, time stamp, update counter and x delta angle output registers
// How it works
// - z accel high word signed, 12.25 mm/s2
// - extra z accel bits in lower word
// - accel high and low form 32 bits
// - temperature signed, 0.1 C per count
// - unsigned elapsed time since sync, 49.02 us
// - time stamp valid in scaled sync mode
// - update loads stamp of last sample
// - counter zero after power-on or reset command
// - counter increments per update, wraps to zero
// - counter is unsigned full 16 bits
// - delta angle by trapezoidal integration over window
// - window length is decimation setting plus one
// - internal sample clock runs 2000 samples/s
// - x delta angle high word signed, 2160/2^15
// - delta angle low and high form 32 bits
`timescale 1ns/1ps
`default_nettype none

module imu_output_data_registers
    import imu_output_pkg::*;
#(
    parameter int SAMPLE_DIV_CYCLES = SAMPLE_CYCLES,
    parameter int STAMP_DIV_CYCLES  = STAMP_TICK_CYCLES,
    parameter int DEC_WIDTH         = 16
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_mosi,
    input  wire logic        i_sync,
    input  wire logic [31:0] i_accel_z,
    input  wire logic [15:0] i_temperature,
    input  wire logic [31:0] i_gyro_x,
    output logic             o_miso,
    output logic             o_miso_oe_n,
    output logic             o_sample_ready_output,
    output logic [15:0]      o_miscellaneous_control
);

    // ---------------------------------------------------------------
    // pin synchronisers: stage one is read only by stage two
    logic [3:0] pin_meta_r;
    logic [3:0] pin_sync_r;
    logic [3:0] pin_prev_r;

    // two flops per pin, third flop keeps last value for edge finding
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_meta_r <= 4'hB;
            pin_sync_r <= 4'hB;
            pin_prev_r <= 4'hB;
        end else begin
            pin_meta_r <= {i_sclk, i_sync, i_cs_n, i_mosi};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    logic sclk_s;
    logic cs_n_s;
    logic mosi_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic sync_rise;

    // edge detection on synchronised copies only
    assign sclk_s    = pin_sync_r[3];
    assign cs_n_s    = pin_sync_r[1];
    assign mosi_s    = pin_sync_r[0];
    assign sclk_rise = pin_sync_r[3] & ~pin_prev_r[3];
    assign sclk_fall = ~pin_sync_r[3] & pin_prev_r[3];
    assign sync_rise = pin_sync_r[2] & ~pin_prev_r[2];
    assign cs_fall   = ~pin_sync_r[1] & pin_prev_r[1];

    // ---------------------------------------------------------------
    // register storage; output words written only by the update logic, control and decimation by serial writes
    logic [15:0] z_accel_low_word_r;
    logic [15:0] z_accel_high_word_r;
    logic [15:0] internal_temperature_r;
    logic [15:0] sync_elapsed_time_r;
    logic [15:0] update_counter_r;
    logic [15:0] x_rotation_delta_low_word_r;
    logic [15:0] x_rotation_delta_high_word_r;
    logic [15:0] miscellaneous_control_r;
    logic [15:0] decimation_r;

    // read decode of the register map
    function automatic logic [15:0] reg_read(input logic [6:0] addr);
        logic [6:0] word_addr;
        word_addr = {addr[6:1], 1'b0};
        unique case (word_addr)
            ADDR_Z_ACCEL_LOW:      reg_read = z_accel_low_word_r;
            ADDR_Z_ACCEL_HIGH:     reg_read = z_accel_high_word_r;
            ADDR_TEMPERATURE:      reg_read = internal_temperature_r;
            ADDR_SYNC_ELAPSED:     reg_read = sync_elapsed_time_r;
            ADDR_UPDATE_COUNTER:   reg_read = update_counter_r;
            ADDR_X_ROT_DELTA_LOW:  reg_read = x_rotation_delta_low_word_r;
            ADDR_X_ROT_DELTA_HIGH: reg_read = x_rotation_delta_high_word_r;
            ADDR_MISC_CONTROL:     reg_read = miscellaneous_control_r;
            ADDR_DECIMATION:       reg_read = decimation_r;
            default:               reg_read = READ_UNMAPPED;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // serial slave, clock idles high, sample on rise, launch on fall
    spi_state_t  spi_state_r;
    spi_state_t  spi_state_nxt;
    logic [3:0]  bit_cnt_r;
    logic [3:0]  bit_cnt_nxt;
    logic [15:0] rx_r;
    logic [15:0] rx_nxt;
    logic [15:0] tx_r;
    logic [15:0] tx_nxt;
    logic [15:0] resp_r;
    logic [15:0] resp_nxt;
    logic [15:0] misc_nxt;
    logic [15:0] dec_nxt;
    logic        soft_rst_r;
    logic        soft_rst_nxt;
    logic        launched_r;
    logic        launched_nxt;

    // frame engine; a read answers in the next frame
    always_comb begin
        logic [15:0] frame;
        logic [6:0]  addr;
        frame         = {rx_r[14:0], mosi_s};
        addr          = frame[FRAME_ADDR_LSB +: 7];
        spi_state_nxt = spi_state_r;
        bit_cnt_nxt   = bit_cnt_r;
        rx_nxt        = rx_r;
        tx_nxt        = tx_r;
        resp_nxt      = resp_r;
        misc_nxt      = miscellaneous_control_r;
        dec_nxt       = decimation_r;
        soft_rst_nxt  = 1'b0;
        launched_nxt  = launched_r;
        unique case (spi_state_r)
            SPI_IDLE: begin
                if (cs_fall) begin
                    spi_state_nxt = SPI_SHIFT;
                    tx_nxt        = resp_r;
                    bit_cnt_nxt   = 4'h0;
                    launched_nxt  = 1'b0;
                end
            end
            SPI_SHIFT: begin
                if (cs_n_s) begin
                    // aborted frame: nothing is decoded
                    spi_state_nxt = SPI_IDLE;
                end else if (sclk_rise) begin
                    rx_nxt       = frame;
                    bit_cnt_nxt  = bit_cnt_r + 4'h1;
                    launched_nxt = 1'b1;
                    if (bit_cnt_r == 4'(FRAME_BITS - 1)) begin
                        if (!frame[FRAME_WRITE_BIT]) begin
                            resp_nxt = reg_read(addr);
                        end else begin
                            // byte writes: even address low byte, odd high byte
                            unique case ({addr[6:1], 1'b0})
                                ADDR_MISC_CONTROL: begin
                                    if (addr[0]) misc_nxt[15:8] = frame[7:0];
                                    else         misc_nxt[7:0]  = frame[7:0];
                                end
                                ADDR_DECIMATION: begin
                                    if (addr[0]) dec_nxt[15:8] = frame[7:0];
                                    else         dec_nxt[7:0]  = frame[7:0];
                                end
                                ADDR_COMMAND: begin
                                    soft_rst_nxt = ~addr[0] & frame[CMD_SOFT_RESET_BIT];
                                end
                                default: begin
                                    // read-only or unmapped: write dropped
                                end
                            endcase
                        end
                    end
                end else if (sclk_fall && launched_r) begin
                    // first fall only opens the frame, msb already on the pin
                    tx_nxt = {tx_r[14:0], 1'b0};
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            spi_state_r             <= SPI_IDLE;
            bit_cnt_r               <= 4'h0;
            rx_r                    <= 16'h0000;
            tx_r                    <= 16'h0000;
            resp_r                  <= 16'h0000;
            miscellaneous_control_r <= MISC_CONTROL_RESET;
            decimation_r            <= DECIMATION_RESET;
            soft_rst_r              <= 1'b0;
            launched_r              <= 1'b0;
        end else begin
            spi_state_r             <= spi_state_nxt;
            bit_cnt_r               <= bit_cnt_nxt;
            rx_r                    <= rx_nxt;
            tx_r                    <= tx_nxt;
            resp_r                  <= resp_nxt;
            miscellaneous_control_r <= misc_nxt;
            decimation_r            <= dec_nxt;
            soft_rst_r              <= soft_rst_nxt;
            launched_r              <= launched_nxt;
        end
    end

    // miso driven only inside a frame
    assign o_miso                  = tx_r[15];
    assign o_miso_oe_n             = (spi_state_r != SPI_SHIFT);
    assign o_miscellaneous_control = miscellaneous_control_r;

    // ---------------------------------------------------------------
    // sample clock and elapsed-time base
    logic [1:0]  sync_mode;
    logic [31:0] sample_div_r;
    logic [31:0] sample_div_nxt;
    logic [31:0] stamp_div_r;
    logic [31:0] stamp_div_nxt;
    logic [15:0] stamp_cnt_r;
    logic [15:0] stamp_cnt_nxt;
    logic        sample_tick;

    assign sync_mode = miscellaneous_control_r[SYNC_MODE_LSB +: 2];

    // direct mode samples on sync edges, otherwise the 2000 sps divider
    assign sample_tick = (sync_mode == SYNC_MODE_DIRECT) ? sync_rise
                       : (sample_div_r == 32'(SAMPLE_DIV_CYCLES - 1));

    // stamp counts 49.02 us units from the last sync edge
    always_comb begin
        sample_div_nxt = sample_tick ? 32'h0000_0000 : sample_div_r + 32'h0000_0001;
        stamp_div_nxt  = stamp_div_r + 32'h0000_0001;
        stamp_cnt_nxt  = stamp_cnt_r;
        if (sync_rise) begin
            stamp_div_nxt = 32'h0000_0000;
            stamp_cnt_nxt = 16'h0000;
        end else if (stamp_div_r == 32'(STAMP_DIV_CYCLES - 1)) begin
            stamp_div_nxt = 32'h0000_0000;
            stamp_cnt_nxt = stamp_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sample_div_r <= 32'h0000_0000;
            stamp_div_r  <= 32'h0000_0000;
            stamp_cnt_r  <= 16'h0000;
        end else begin
            sample_div_r <= sample_div_nxt;
            stamp_div_r  <= stamp_div_nxt;
            stamp_cnt_r  <= stamp_cnt_nxt;
        end
    end

    // ---------------------------------------------------------------
    // integration window and output update
    logic [DEC_WIDTH-1:0] win_cnt_r;
    logic [DEC_WIDTH-1:0] win_cnt_nxt;
    logic signed [49:0]   acc_r;
    logic signed [49:0]   acc_nxt;
    logic signed [31:0]   gyro_prev_r;
    logic signed [31:0]   gyro_prev_nxt;
    logic signed [49:0]   acc_sum;
    logic signed [73:0]   delta_prod;
    logic [31:0]          delta_word;
    logic                 update;
    logic [15:0] z_low_nxt;
    logic [15:0] z_high_nxt;
    logic [15:0] temp_nxt;
    logic [15:0] stamp_nxt;
    logic [15:0] counter_nxt;
    logic [15:0] xd_low_nxt;
    logic [15:0] xd_high_nxt;
    logic        ready_nxt;
    logic        ready_r;

    // trapezoid: each sample plus its predecessor, then times 1/(2 fs)
    assign acc_sum    = acc_r + 50'(signed'(i_gyro_x)) + 50'(gyro_prev_r);
    assign delta_prod = acc_sum * $signed({1'b0, DELTA_RECIP});
    assign delta_word = delta_prod[63:32];
    assign update     = sample_tick && (win_cnt_r >= decimation_r[DEC_WIDTH-1:0]);

    always_comb begin
        win_cnt_nxt   = win_cnt_r;
        acc_nxt       = acc_r;
        gyro_prev_nxt = gyro_prev_r;
        z_low_nxt     = z_accel_low_word_r;
        z_high_nxt    = z_accel_high_word_r;
        temp_nxt      = internal_temperature_r;
        stamp_nxt     = sync_elapsed_time_r;
        counter_nxt   = update_counter_r;
        xd_low_nxt    = x_rotation_delta_low_word_r;
        xd_high_nxt   = x_rotation_delta_high_word_r;
        ready_nxt     = 1'b0;
        if (soft_rst_r) begin
            // reset command restarts window and count
            win_cnt_nxt   = '0;
            acc_nxt       = '0;
            gyro_prev_nxt = '0;
            counter_nxt   = UPDATE_COUNTER_RESET;
        end else if (sample_tick) begin
            gyro_prev_nxt = signed'(i_gyro_x);
            if (update) begin
                // every word of the update taken from the same last sample
                win_cnt_nxt = '0;
                acc_nxt     = '0;
                z_high_nxt  = i_accel_z[31:16];
                z_low_nxt   = i_accel_z[15:0];
                temp_nxt    = i_temperature;
                stamp_nxt   = stamp_cnt_r;
                counter_nxt = update_counter_r + 16'h0001;
                xd_high_nxt = delta_word[31:16];
                xd_low_nxt  = delta_word[15:0];
                ready_nxt   = 1'b1;
            end else begin
                win_cnt_nxt = win_cnt_r + 1'b1;
                acc_nxt     = acc_sum;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            win_cnt_r                    <= '0;
            acc_r                        <= '0;
            gyro_prev_r                  <= '0;
            z_accel_low_word_r           <= OUTPUT_WORD_RESET;
            z_accel_high_word_r          <= OUTPUT_WORD_RESET;
            internal_temperature_r       <= OUTPUT_WORD_RESET;
            sync_elapsed_time_r          <= OUTPUT_WORD_RESET;
            update_counter_r             <= UPDATE_COUNTER_RESET;
            x_rotation_delta_low_word_r  <= OUTPUT_WORD_RESET;
            x_rotation_delta_high_word_r <= OUTPUT_WORD_RESET;
            ready_r                      <= 1'b0;
        end else begin
            win_cnt_r                    <= win_cnt_nxt;
            acc_r                        <= acc_nxt;
            gyro_prev_r                  <= gyro_prev_nxt;
            z_accel_low_word_r           <= z_low_nxt;
            z_accel_high_word_r          <= z_high_nxt;
            internal_temperature_r       <= temp_nxt;
            sync_elapsed_time_r          <= stamp_nxt;
            update_counter_r             <= counter_nxt;
            x_rotation_delta_low_word_r  <= xd_low_nxt;
            x_rotation_delta_high_word_r <= xd_high_nxt;
            ready_r                      <= ready_nxt;
        end
    end

    // one-cycle pulse per data update; host can time it for fs / (decimation + 1)
    assign o_sample_ready_output = ready_r;

    // sclk level itself is only used through its edges
    logic unused_sclk;
    assign unused_sclk = sclk_s;

endmodule

`default_nettype wire

// ---- rtl/imu_output_pkg.sv ----
// constants shared by the inertial output register block
package imu_output_pkg;

    // register addresses on the serial port (byte addresses, 16-bit words)
    localparam logic [6:0] ADDR_Z_ACCEL_LOW       = 7'h18;
    localparam logic [6:0] ADDR_Z_ACCEL_HIGH      = 7'h1A;
    localparam logic [6:0] ADDR_TEMPERATURE       = 7'h1C;
    localparam logic [6:0] ADDR_SYNC_ELAPSED      = 7'h1E;
    localparam logic [6:0] ADDR_UPDATE_COUNTER    = 7'h22;
    localparam logic [6:0] ADDR_X_ROT_DELTA_LOW   = 7'h24;
    localparam logic [6:0] ADDR_X_ROT_DELTA_HIGH  = 7'h26;
    localparam logic [6:0] ADDR_MISC_CONTROL      = 7'h60;
    localparam logic [6:0] ADDR_DECIMATION        = 7'h64;
    localparam logic [6:0] ADDR_COMMAND           = 7'h68;

    // reset values
    localparam logic [15:0] MISC_CONTROL_RESET    = 16'h0000;
    localparam logic [15:0] DECIMATION_RESET      = 16'h0000;
    localparam logic [15:0] UPDATE_COUNTER_RESET  = 16'h0000;
    localparam logic [15:0] OUTPUT_WORD_RESET     = 16'h0000;
    localparam logic [15:0] READ_UNMAPPED         = 16'h0000;

    // miscellaneous control: sync mode field [3:2]
    localparam int          SYNC_MODE_LSB         = 2;
    localparam logic [1:0]  SYNC_MODE_INTERNAL    = 2'b00;
    localparam logic [1:0]  SYNC_MODE_DIRECT      = 2'b01;
    localparam logic [1:0]  SYNC_MODE_SCALED      = 2'b10;

    // command register: software reset bit
    localparam int          CMD_SOFT_RESET_BIT    = 7;

    // serial frame layout
    localparam int          FRAME_BITS            = 16;
    localparam int          FRAME_WRITE_BIT       = 15;
    localparam int          FRAME_ADDR_LSB        = 8;

    // timing
    localparam int          CLOCK_PERIOD_PS       = 10000;
    localparam int          SAMPLE_RATE_SPS       = 2000;
    localparam int          SAMPLE_PERIOD_PS      = 1000000000 / SAMPLE_RATE_SPS * 1000;
    localparam int          SAMPLE_CYCLES         = SAMPLE_PERIOD_PS / CLOCK_PERIOD_PS;
    localparam int          STAMP_LSB_PS          = 49020000;
    localparam int          STAMP_TICK_CYCLES     = STAMP_LSB_PS / CLOCK_PERIOD_PS;

    // 2^32 / (2 * fs): trapezoid halving and 1/fs as one fixed-point multiply
    localparam logic [22:0] DELTA_RECIP           = 23'((64'h1 << 32) / (2 * SAMPLE_RATE_SPS));

    // serial engine states
    typedef enum logic [1:0] {
        SPI_IDLE  = 2'b01,
        SPI_SHIFT = 2'b10
    } spi_state_t;

endpackage

// ---- verification/imu_output_properties.sv ----
// assertions on the output register block ports
`timescale 1ns/1ps
`default_nettype none
module imu_output_properties #(
    parameter int SAMPLE_DIV_CYCLES = 50,
    parameter int STAMP_DIV_CYCLES  = 5,
    parameter int DEC_WIDTH         = 16
) (
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    input wire logic        i_sclk,
    input wire logic        i_cs_n,
    input wire logic        i_mosi,
    input wire logic        i_sync,
    input wire logic [31:0] i_accel_z,
    input wire logic [15:0] i_temperature,
    input wire logic [31:0] i_gyro_x,
    input wire logic        o_miso,
    input wire logic        o_miso_oe_n,
    input wire logic        o_sample_ready_output,
    input wire logic [15:0] o_miscellaneous_control
);
    logic [31:0] gap_r;
    logic [31:0] gap_nxt;
    logic        seen_r;
    logic        seen_nxt;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // cycles since the last update; outside direct mode a repetition cannot come sooner than the divider length
    always_comb begin
        gap_nxt  = o_sample_ready_output ? 32'h0 : gap_r + 32'h1;
        seen_nxt = seen_r | o_sample_ready_output;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gap_r  <= 32'h0;
            seen_r <= 1'b0;
        end else begin
            gap_r  <= gap_nxt;
            seen_r <= seen_nxt;
        end
    end

    // rise of the serial clock, then its high half inside a frame
    sequence s_high_half;
        $rose(i_sclk) ##1 (i_sclk && !i_cs_n) [*3];
    endsequence

    property p_miso_stable;
        s_high_half |-> $stable(o_miso);
    endproperty
    property p_oe_on;
        $fell(i_cs_n) |-> ##[1:5] !o_miso_oe_n;
    endproperty
    property p_oe_off;
        $rose(i_cs_n) |-> ##[1:5] o_miso_oe_n;
    endproperty
    property p_oe_idle;
        i_cs_n [*6] |-> o_miso_oe_n;
    endproperty
    property p_ready_pulse;
        o_sample_ready_output |=> !o_sample_ready_output;
    endproperty
    property p_ready_gap;
        o_sample_ready_output && seen_r && o_miscellaneous_control[3:2] != 2'b01
            |-> gap_r >= SAMPLE_DIV_CYCLES - 1;
    endproperty
    property p_quiet_after_reset;
        $rose(i_rst_n) |-> !o_sample_ready_output [*8];
    endproperty
    property p_misc_in_frame;
        !$stable(o_miscellaneous_control) |-> !$past(i_cs_n, 4);
    endproperty

    a_miso_stable: assert property (p_miso_stable) else $error("miso moved in high half");
    a_oe_on: assert property (p_oe_on) else $error("miso not driven after select");
    a_oe_off: assert property (p_oe_off) else $error("miso still driven after deselect");
    a_oe_idle: assert property (p_oe_idle) else $error("miso driven while deselected");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    a_ready_gap: assert property (p_ready_gap) else $error("updates closer than one sample");
    a_quiet_after_reset: assert property (p_quiet_after_reset) else $error("early update");
    a_misc_in_frame: assert property (p_misc_in_frame) else $error("control moved outside frame");
endmodule
`default_nettype wire

// ---- verification/spi_host_model.sv ----
// serial host model: mode 3 frames of sixteen bits
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic        o_sclk,
    output logic        o_cs_n,
    output logic        o_mosi,
    input  wire logic   i_miso,
    input  wire logic   i_miso_oe_n,
    output logic [15:0] o_rsp
);
    event frame_done;
    logic last_r;
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
        o_rsp  = 16'h0000;
        last_r = 1'b0;
    end
    // data set on the falling clock, read late in the high half where it surely stands
    task automatic xfer(input logic [15:0] cmd);
        #3.7;
        o_cs_n = 1'b0;
        o_mosi = cmd[15];
        #62.5;
        for (int i = 15; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_mosi = cmd[i];
            #62.5;
            o_sclk = 1'b1;
            #62.5;
            last_r = i_miso_oe_n ? ~last_r : i_miso; // released line shows no stale bit
            o_rsp[i] = last_r;
        end
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi; // deselected data line keeps moving
        #125;
        -> frame_done;
    endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the output register block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import imu_output_pkg::*;
;
    localparam int SDIV  = 3000;
    localparam int TDIV  = 5;
    localparam int LIMIT = 20000;
    typedef struct {bit on; logic [15:0] val; int tol; string name;} note_t;
    logic        clock, rst_n, sclk, cs_n, mosi, sync, miso, miso_oe_n, ready;
    logic [31:0] accel, gyro;
    logic [15:0] temp, misc, rsp;
    int          failures, checks, nready, seed, n;
    note_t       exp_q[$];
    note_t       pend;

    imu_output_data_registers #(.SAMPLE_DIV_CYCLES(SDIV), .STAMP_DIV_CYCLES(TDIV)) i_dut (
        .i_clock(clock), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
        .i_sync(sync), .i_accel_z(accel), .i_temperature(temp), .i_gyro_x(gyro),
        .o_miso(miso), .o_miso_oe_n(miso_oe_n), .o_sample_ready_output(ready),
        .o_miscellaneous_control(misc));
    spi_host_model i_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso),
        .i_miso_oe_n(miso_oe_n), .o_rsp(rsp));

    always #5 clock = ~clock;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
        checks++;
        if (seen !== expv) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // gap in cycles up to the next update pulse, bounded; counts the update when seen,
    // since a clocked counter would still lag the register at this negedge
    task automatic wait_ready(output int gap);
        gap = 0;
        do begin
            @(negedge clock);
            gap++;
        end while (ready !== 1'b1 && gap < LIMIT);
        if (gap >= LIMIT) begin
            failures++;
            print_verdict();
        end
        nready++;
    endtask
    // a frame answers the previous command, so its note waits one frame
    task automatic xf(input logic [15:0] cmd, input note_t nx);
        exp_q.push_back(pend);
        pend = nx;
        i_host.xfer(cmd);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] v, input int tol, input string nm);
        xf({1'b0, a, 8'h00}, '{1'b1, v, tol, nm});
    endtask
    task automatic wr(input logic [15:0] cmd);
        xf(cmd, '{1'b0, 16'h0000, 0, ""});
    endtask
    // trapezoid over m half-sums of a steady rate, then the 1/(2 fs) scale
    function automatic logic [15:0] delta_w(input logic [31:0] g, input int m, input bit hi);
        longint d;
        d = longint'(m) * longint'($signed(g)) * longint'(DELTA_RECIP);
        d = d >>> 32;
        return hi ? d[31:16] : d[15:0];
    endfunction

    // each finished frame answers the oldest note; a stamp may be off by up to three ticks
    always @(i_host.frame_done) begin : watch
        note_t e;
        e = exp_q.pop_front();
        if (e.on && e.tol > 0 && (rsp - e.val <= e.tol || e.val - rsp <= e.tol))
            chk(e.name, e.val, e.val);
        else if (e.on)
            chk(e.name, rsp, e.val);
    end

    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        sync = 1'b0;
        accel = 32'h0;
        temp = 16'h0;
        gyro = 32'h0;
        seed = 75;
        pend = '{1'b0, 16'h0000, 0, ""};
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        // contents before the first update
        chk("misc_control", misc, MISC_CONTROL_RESET);
        rd(ADDR_UPDATE_COUNTER, 16'h0000, 0, "counter");
        rd(ADDR_Z_ACCEL_HIGH, OUTPUT_WORD_RESET, 0, "accel_high");
        rd(ADDR_X_ROT_DELTA_HIGH, OUTPUT_WORD_RESET, 0, "delta_high");
        wr(16'h0000);
        // fresh random samples, two updates so the trapezoid sees them twice
        for (int k = 0; k < 3; k++) begin
            wait_ready(n);
            @(posedge clock);
            accel <= $random(seed);
            temp <= 16'($random(seed));
            gyro <= $random(seed);
            wait_ready(n);
            wait_ready(n);
            chk("sample_gap", n, SDIV);
            rd(ADDR_UPDATE_COUNTER, nready[15:0], 0, "counter");
            rd(ADDR_Z_ACCEL_LOW, accel[15:0], 0, "accel_low");
            rd(ADDR_Z_ACCEL_HIGH, accel[31:16], 0, "accel_high");
            rd(ADDR_TEMPERATURE, temp, 0, "temperature");
            rd(ADDR_X_ROT_DELTA_LOW, delta_w(gyro, 2, 1'b0), 0, "delta_low");
            rd(ADDR_X_ROT_DELTA_HIGH, delta_w(gyro, 2, 1'b1), 0, "delta_high");
            rd(7'h40, READ_UNMAPPED, 0, "unmapped");
            wr({1'b1, ADDR_TEMPERATURE, 8'h55});
            rd(ADDR_TEMPERATURE, temp, 0, "temperature_ro");
            wr(16'h0000);
        end
        // command reset clears the counter, the next update counts one
        wait_ready(n);
        wr({1'b1, ADDR_COMMAND, 8'h80});
        nready = 0;
        rd(ADDR_UPDATE_COUNTER, 16'h0000, 0, "counter_cleared");
        wr(16'h0000);
        wait_ready(n);
        rd(ADDR_UPDATE_COUNTER, 16'h0001, 0, "counter_step");
        // decimation of two: windows of three samples
        wr({1'b1, ADDR_DECIMATION, 8'h02});
        wait_ready(n);
        wait_ready(n);
        wait_ready(n);
        chk("window_gap", n, 3 * SDIV);
        rd(ADDR_X_ROT_DELTA_HIGH, delta_w(gyro, 6, 1'b1), 0, "delta_window");
        rd(ADDR_X_ROT_DELTA_LOW, delta_w(gyro, 6, 1'b0), 0, "delta_window_low");
        // scaled sync mode: stamp counts from the last sync edge
        wr({1'b1, ADDR_MISC_CONTROL, 8'h08});
        repeat (8) @(posedge clock);
        chk("misc_control", misc, 16'h0008);
        wait_ready(n);
        @(posedge clock);
        sync <= 1'b1;
        repeat (4) @(posedge clock);
        sync <= 1'b0;
        wait_ready(n);
        rd(ADDR_SYNC_ELAPSED, 16'((n - 3) / TDIV), 3, "time_stamp");
        // direct mode: the sync edge is the sample; two sync flops and one load later
        wr({1'b1, ADDR_MISC_CONTROL, 8'h04});
        wr({1'b1, ADDR_DECIMATION, 8'h00});
        @(posedge clock);
        sync <= 1'b1;
        wait_ready(n);
        chk("direct_gap", n, 4);
        @(negedge clock);
        print_verdict();
    end
endmodule

bind imu_output_data_registers imu_output_properties #(
    .SAMPLE_DIV_CYCLES(SAMPLE_DIV_CYCLES), .STAMP_DIV_CYCLES(STAMP_DIV_CYCLES),
    .DEC_WIDTH(DEC_WIDTH)
) i_props (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_mosi(i_mosi),
    .i_sync(i_sync), .i_accel_z(i_accel_z), .i_temperature(i_temperature), .i_gyro_x(i_gyro_x),
    .o_miso(o_miso), .o_miso_oe_n(o_miso_oe_n), .o_sample_ready_output(o_sample_ready_output),
    .o_miscellaneous_control(o_miscellaneous_control)
);
`default_nettype wire
